// ---- asr_map.svh ----
/*
 Pin timing, widths and idle pin levels of the asynchronous SRAM host controller.
 Assumes a single 100 MHz system clock; all times are in nanoseconds.
*/
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// System clock rate and conversion base
`define ASR_CLK_MHZ       100
`define ASR_NS_PER_US     1000

// Bus and counter widths, lane count and synchroniser stages
`define ASR_ADDR_W        19
`define ASR_DATA_W        16
`define ASR_LANES         2
`define ASR_CNT_W         4
`define ASR_SYNC_STAGES   2

// Device timing figures in ns
`define ASR_T_RC_NS       70
`define ASR_T_AA_NS       70
`define ASR_T_OHZ_NS      30
`define ASR_T_WC_NS       70
`define ASR_T_CW_NS       60
`define ASR_T_AW_NS       60
`define ASR_T_BW_NS       60
`define ASR_T_WP_NS       50
`define ASR_T_DW_NS       30

// Idle pin levels
`define ASR_SEL_LOW_IDLE  1'h1
`define ASR_SEL_HIGH_IDLE 1'h0
`define ASR_STROBE_IDLE   1'h1
`define ASR_LANE_IDLE     1'h1
`define ASR_DRIVE_IDLE    1'h0

`endif

// ---- asr_pkg.sv ----
/*
 Types and timing helpers of the asynchronous SRAM host controller.
 Assumes asr_map.svh is on the include path.
*/
`include "asr_map.svh"

package asr_pkg;

   typedef logic [`ASR_CNT_W-1:0] asr_cnt_t;

   // One user request
   typedef struct packed {
      logic                    write;
      logic [`ASR_ADDR_W-1:0]  addr;
      logic [`ASR_DATA_W-1:0]  wdata;
      logic [`ASR_LANES-1:0]   lane_en;   // Bit 0 low byte, bit 1 high byte, 1 = used
   } asr_req_t;

   // Everything the controller drives toward the memory
   typedef struct packed {
      logic [`ASR_ADDR_W-1:0]  addr;
      logic                    sram_select_active_low;
      logic                    sram_select_active_high;
      logic                    sram_write_strobe_n;
      logic                    sram_output_enable_n;
      logic                    low_byte_lane_enable_n;
      logic                    high_byte_lane_enable_n;
      logic [`ASR_DATA_W-1:0]  data;
      logic                    data_oe;
   } asr_pins_t;

   typedef enum logic [2:0] {
      ASR_IDLE,
      ASR_READ,
      ASR_TURN,
      ASR_WSETUP,
      ASR_WPULSE,
      ASR_WRECOV
   } asr_state_t;

   // Least time in ns to whole clock cycles, rounded up, never below one
   function automatic int asr_cycles(input int ns);
      int c;
      c = (ns * `ASR_CLK_MHZ + `ASR_NS_PER_US - 1) / `ASR_NS_PER_US;
      if (c < 1) begin
         c = 1;
      end
      return c;
   endfunction

   function automatic int asr_max(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

endpackage

// ---- asr_sync.sv ----
/*
 Two flip-flop synchroniser for the data pins read back from the memory.
 Assumes the input is asynchronous to clk_in; only the second stage is read.
*/
`timescale 1ns/1ns

module asr_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   // Data
   input  wire logic [W-1:0]  async_in,
   output logic      [W-1:0]  sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } asr_sync_state_t;

   asr_sync_state_t st_reg;
   asr_sync_state_t st_next;

   // Shift the pin value through both stages
   always_comb begin
      st_next        = st_reg;
      st_next.stage1 = async_in;
      st_next.stage2 = st_reg.stage1;
   end

   // Register the state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.stage2;

endmodule // asr_sync

// ---- asr_ctrl.sv ----
/*
 Host controller for an asynchronous 16-bit static RAM: turns one user request at a
 time into a timed read or write sequence on the memory pins.
 Assumes the memory pins are wired straight to the part and that the data bus
 resolves from data_oe outside this module.
*/
`timescale 1ns/1ns
`include "asr_map.svh"

module asr_ctrl (
   // Clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   // User request
   input  wire logic                     req_valid_in,
   input  wire asr_pkg::asr_req_t        req_in,
   output logic                          req_ready_out,
   // User answer
   output logic                          rsp_valid_out,
   output logic [`ASR_DATA_W-1:0]        rsp_rdata_out,
   // Memory pins
   output asr_pkg::asr_pins_t            pins_out,
   input  wire logic [`ASR_DATA_W-1:0]   sram_data_in
);

   // Cycle counts derived from the timing figures
   // Read: pins stand for the access time plus the synchroniser delay
   localparam int RC_CYC   = asr_pkg::asr_cycles(`ASR_T_RC_NS);
   localparam int AA_CYC   = asr_pkg::asr_cycles(`ASR_T_AA_NS);
   localparam int RD_CYC   = asr_pkg::asr_max(RC_CYC, AA_CYC) + `ASR_SYNC_STAGES;
   // Turnaround after a read: the memory's output-off time
   localparam int TURN_CYC = asr_pkg::asr_cycles(`ASR_T_OHZ_NS);
   // Write pulse: long enough for select, address, lane and data setup
   localparam int SEL_CYC  = asr_pkg::asr_max(asr_pkg::asr_cycles(`ASR_T_CW_NS),
                                              asr_pkg::asr_cycles(`ASR_T_AW_NS));
   localparam int LANE_CYC = asr_pkg::asr_max(asr_pkg::asr_cycles(`ASR_T_BW_NS), SEL_CYC);
   localparam int WP_CYC   = asr_pkg::asr_max(asr_pkg::asr_max(asr_pkg::asr_cycles(`ASR_T_WP_NS),
                                              asr_pkg::asr_cycles(`ASR_T_DW_NS)), LANE_CYC);
   // Recovery: the rest of the write cycle, never less than one hold cycle
   localparam int WC_REST  = asr_pkg::asr_cycles(`ASR_T_WC_NS) - 1 - WP_CYC;
   localparam int REC_CYC  = asr_pkg::asr_max(WC_REST, 1);

   // Counter loads: a load of n keeps a state for n + 1 cycles
   localparam asr_pkg::asr_cnt_t RD_LOAD   = asr_pkg::asr_cnt_t'(RD_CYC - 1);
   localparam asr_pkg::asr_cnt_t TURN_LOAD = asr_pkg::asr_cnt_t'(TURN_CYC - 1);
   localparam asr_pkg::asr_cnt_t WP_LOAD   = asr_pkg::asr_cnt_t'(WP_CYC - 1);
   localparam asr_pkg::asr_cnt_t REC_LOAD  = asr_pkg::asr_cnt_t'(REC_CYC - 1);

   // All state in one struct: sequencer, counter, pin image and answer
   typedef struct packed {
      asr_pkg::asr_state_t        state;
      asr_pkg::asr_cnt_t          cnt;
      asr_pkg::asr_pins_t         pins;
      logic                       rsp_valid;
      logic [`ASR_DATA_W-1:0]     rdata;
   } asr_ctrl_state_t;

   // Current and next state, synchronised read data
   asr_ctrl_state_t          st_reg;
   asr_ctrl_state_t          st_next;
   logic [`ASR_DATA_W-1:0]   rd_sync;

   // Pins that leave the memory in standby, bus released
   function automatic asr_pkg::asr_pins_t idle_pins(input logic [`ASR_ADDR_W-1:0] addr);
      asr_pkg::asr_pins_t p;
      p                          = '0;
      p.addr                     = addr;
      p.sram_select_active_low   = `ASR_SEL_LOW_IDLE;
      p.sram_select_active_high  = `ASR_SEL_HIGH_IDLE;
      p.sram_write_strobe_n      = `ASR_STROBE_IDLE;
      p.sram_output_enable_n     = `ASR_STROBE_IDLE;
      p.low_byte_lane_enable_n   = `ASR_LANE_IDLE;
      p.high_byte_lane_enable_n  = `ASR_LANE_IDLE;
      p.data_oe                  = `ASR_DRIVE_IDLE;
      return p;
   endfunction

   // True when a running count has reached its last cycle
   function automatic logic cnt_done(input asr_pkg::asr_cnt_t c);
      return (c == '0);
   endfunction

   // One step down of a running count
   function automatic asr_pkg::asr_cnt_t cnt_step(input asr_pkg::asr_cnt_t c);
      return c - 1'h1;
   endfunction

   // Read data returns through a two-stage synchroniser
   asr_sync #(
      .W        (`ASR_DATA_W)
   ) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .async_in (sram_data_in),
      .sync_out (rd_sync)
   );

   // Sequencer: one access at a time
   always_comb begin
      st_next           = st_reg;
      st_next.rsp_valid = 1'h0;
      unique case (st_reg.state)
         // Take a request: address, selects and lanes go out together
         asr_pkg::ASR_IDLE: begin
            if (req_valid_in) begin
               st_next.pins                         = idle_pins(req_in.addr);
               st_next.pins.sram_select_active_low  = 1'h0;
               st_next.pins.sram_select_active_high = 1'h1;
               st_next.pins.low_byte_lane_enable_n  = ~req_in.lane_en[0];
               st_next.pins.high_byte_lane_enable_n = ~req_in.lane_en[1];
               if (req_in.write) begin
                  // Output enable stays high, so the memory never drives during a write
                  st_next.pins.data    = req_in.wdata;
                  st_next.pins.data_oe = 1'h1;
                  st_next.state        = asr_pkg::ASR_WSETUP;
               end else begin
                  // Bus stays released; the memory owns it until the turnaround ends
                  st_next.pins.sram_output_enable_n = 1'h0;
                  st_next.cnt                       = RD_LOAD;
                  st_next.state                     = asr_pkg::ASR_READ;
               end
            end
         end

         // Hold the access to its last count, then capture and release
         asr_pkg::ASR_READ: begin
            // Address and selects stand still for the whole access time plus sync delay
            if (cnt_done(st_reg.cnt)) begin
               st_next.rdata     = rd_sync;
               st_next.rsp_valid = 1'h1;
               st_next.pins      = idle_pins(st_reg.pins.addr);
               st_next.cnt       = TURN_LOAD;
               st_next.state     = asr_pkg::ASR_TURN;
            end else begin
               st_next.cnt = cnt_step(st_reg.cnt);
            end
         end

         asr_pkg::ASR_TURN: begin
            // Let the memory release the bus before anyone drives it again
            // The count covers the longest output-off time of the memory
            if (cnt_done(st_reg.cnt)) begin
               st_next.state = asr_pkg::ASR_IDLE;
            end else begin
               st_next.cnt = cnt_step(st_reg.cnt);
            end
         end

         asr_pkg::ASR_WSETUP: begin
            // Strobe falls one cycle after selects, lanes and address settle
            st_next.pins.sram_write_strobe_n = 1'h0;
            st_next.cnt                      = WP_LOAD;
            st_next.state                    = asr_pkg::ASR_WPULSE;
         end

         asr_pkg::ASR_WPULSE: begin
            // Strobe low for the counted pulse width
            if (cnt_done(st_reg.cnt)) begin
               // Strobe rises first; selects, lanes and data hold one more cycle
               st_next.pins.sram_write_strobe_n = 1'h1;
               st_next.cnt                      = REC_LOAD;
               st_next.state                    = asr_pkg::ASR_WRECOV;
            end else begin
               st_next.cnt = cnt_step(st_reg.cnt);
            end
         end

         asr_pkg::ASR_WRECOV: begin
            // Selects, lanes, address and data held past the strobe edge
            if (cnt_done(st_reg.cnt)) begin
               // The answer goes out as the pins return to idle
               st_next.pins      = idle_pins(st_reg.pins.addr);
               st_next.rsp_valid = 1'h1;
               st_next.state     = asr_pkg::ASR_IDLE;
            end else begin
               st_next.cnt = cnt_step(st_reg.cnt);
            end
         end

         // Illegal state code: back to idle with the memory in standby
         default: begin
            st_next.state = asr_pkg::ASR_IDLE;
            st_next.pins  = idle_pins(st_reg.pins.addr);
         end
      endcase
   end

   // Register the state; reset leaves the memory deselected
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_reg       <= '0;
         st_reg.state <= asr_pkg::ASR_IDLE;
         st_reg.pins  <= idle_pins('0);
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs: handshake straight from the state
   assign req_ready_out = (st_reg.state == asr_pkg::ASR_IDLE);
   // Answer and pins straight from flops
   assign rsp_valid_out = st_reg.rsp_valid;
   assign rsp_rdata_out = st_reg.rdata;
   assign pins_out      = st_reg.pins;

endmodule // asr_ctrl

// ---- asr_ctrl_checker.sv ----
/*
 Pin sequence checks of the SRAM host controller.
 Assumes it is bound to asr_ctrl and sees only its ports.
*/
`timescale 1ns/1ns

module asr_ctrl_checker (
   // Clock and reset
   input wire logic               clk_in,
   input wire logic               rst_n_in,
   // User side
   input wire logic               req_valid_in,
   input wire asr_pkg::asr_req_t  req_in,
   input wire logic               req_ready_out,
   input wire logic               rsp_valid_out,
   // Memory side
   input wire asr_pkg::asr_pins_t pins_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Short names for the pin fields
   wire sl = pins_out.sram_select_active_low;
   wire sh = pins_out.sram_select_active_high;
   wire st = pins_out.sram_write_strobe_n;
   wire oe = pins_out.sram_output_enable_n;
   wire doe = pins_out.data_oe;
   // Qualification, idle levels, strobe width, setup and hold
   a_write_qual: assert property (!st |-> !sl && sh && oe && doe) else $error("bad write pins");
   a_read_qual: assert property (!oe |-> st && !sl && sh && !doe) else $error("bad read pins");
   a_idle_pins: assert property (req_ready_out |-> sl && !sh && st && oe && !doe
      && pins_out.low_byte_lane_enable_n && pins_out.high_byte_lane_enable_n) else $error("not idle");
   a_strobe_width: assert property ($fell(st) |-> !st [*6] ##1 st) else $error("strobe width");
   a_write_setup: assert property ($rose(st) |-> !$past(sl, 7) && $past(doe, 7)
      && $past(pins_out.addr, 7) == pins_out.addr) else $error("write setup");
   a_write_end: assert property ($rose(st) |=> rsp_valid_out && !doe && sl && req_ready_out)
      else $error("write end");
   a_read_hold: assert property ($fell(oe) |=> $stable(pins_out.addr) [*8] ##1 oe && rsp_valid_out)
      else $error("read hold");
   a_read_gap: assert property ($rose(oe) |-> !req_ready_out [*3]) else $error("read turnaround");
   a_lane_map: assert property (req_valid_in && req_ready_out |=> pins_out.addr == $past(req_in.addr)
      && {pins_out.high_byte_lane_enable_n, pins_out.low_byte_lane_enable_n} == ~$past(req_in.lane_en))
      else $error("lane map");
endmodule // asr_ctrl_checker

bind asr_ctrl asr_ctrl_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
   .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .pins_out(pins_out));

// ---- asr_sram_model.sv ----
/*
 Behavioural model of the 16-bit asynchronous SRAM.
 Assumes the controller pin struct and the resolved data bus as inputs.
*/
`timescale 1ns/1ns

module asr_sram_model (
   // Pins and resolved bus
   input  wire asr_pkg::asr_pins_t pins_in,
   input  wire logic [15:0]        bus_in,
   // Data driven by the memory
   output logic [15:0]             q_out
);
   logic [15:0] mem [0:255];
   logic [15:0] last_q = 16'h0000;
   logic [15:0] q_next;
   logic        sel;
   logic [1:0]  lane;
   int          dly = 10;   // Access delay, set by the bench
   // Select and lane decode
   assign sel = !pins_in.sram_select_active_low && pins_in.sram_select_active_high;
   assign lane = ~{pins_in.high_byte_lane_enable_n, pins_in.low_byte_lane_enable_n};
   // Write lands at the strobe rise, lane by lane; selects and lanes are read from the
   // pins themselves, so a reset that drops every pin at once writes nothing
   always @(posedge pins_in.sram_write_strobe_n) begin
      if (!pins_in.sram_select_active_low && pins_in.sram_select_active_high) begin
         if (!pins_in.low_byte_lane_enable_n) mem[pins_in.addr[7:0]][7:0] = bus_in[7:0];
         if (!pins_in.high_byte_lane_enable_n) mem[pins_in.addr[7:0]][15:8] = bus_in[15:8];
      end
   end
   // Read drive per lane; a released lane shows the inverted last word
   always @* begin
      q_next = ~last_q;
      if (sel && pins_in.sram_write_strobe_n && !pins_in.sram_output_enable_n) begin
         if (lane[0]) q_next[7:0] = mem[pins_in.addr[7:0]][7:0];
         if (lane[1]) q_next[15:8] = mem[pins_in.addr[7:0]][15:8];
      end
   end
   // Output follows after the access delay, old data held meanwhile
   always @(q_next) q_out <= #(dly) q_next;
   // Remember the word last read
   always @(posedge pins_in.sram_output_enable_n) last_q = q_out;
endmodule // asr_sram_model

// ---- asr_ctrl_test.sv ----
/*
 Self-checking bench of the SRAM host controller.
 Assumes asr_ctrl, its checker and asr_sram_model are compiled with it.
*/
`timescale 1ns/1ns

module asr_ctrl_test;
   logic               clk_in = 1'h0;
   logic               rst_n_in = 1'h0;
   logic               req_valid_in = 1'h0;
   asr_pkg::asr_req_t  req_in = '0;
   logic               req_ready_out;
   logic               rsp_valid_out;
   logic [15:0]        rsp_rdata_out;
   asr_pkg::asr_pins_t pins_out;
   logic [15:0]        q_mem;
   logic [15:0]        sram_data_in;
   logic [15:0]        rd;
   int                 bad_count = 0;
   int                 cmp_count = 0;
   // Clock and resolved data bus
   always #5 clk_in = ~clk_in;
   assign sram_data_in = pins_out.data_oe ? pins_out.data : q_mem;
   asr_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
      .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
      .pins_out(pins_out), .sram_data_in(sram_data_in));
   asr_sram_model u_mem (.pins_in(pins_out), .bus_in(sram_data_in), .q_out(q_mem));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Inputs change 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   function automatic logic [15:0] idle_bits();
      return {8'h00, pins_out.sram_select_active_low, pins_out.sram_select_active_high,
         pins_out.sram_write_strobe_n, pins_out.sram_output_enable_n, pins_out.low_byte_lane_enable_n,
         pins_out.high_byte_lane_enable_n, pins_out.data_oe, req_ready_out};
   endfunction
   // One request, then its answer; read data lands in rd
   task automatic xfer(input logic w, input logic [18:0] a, input logic [15:0] d, input logic [1:0] le);
      int n;
      n = 0;
      req_in = '{w, a, d, le};
      req_valid_in = 1'h1;
      while (req_ready_out !== 1'h1 && n < 40) begin
         tick(1);
         n++;
      end
      tick(1);
      req_valid_in = 1'h0;
      while (rsp_valid_out !== 1'h1 && n < 40) begin
         tick(1);
         n++;
      end
      check({15'h0, n < 40}, 16'h0001);
      rd = rsp_rdata_out;
      tick(1);
   endtask
   // Back-to-back words at two addresses
   task automatic t_word();
      xfer(1'h1, 19'h00005, 16'hA5C3, 2'h3);
      xfer(1'h1, 19'h00006, 16'h5A3C, 2'h3);
      xfer(1'h0, 19'h00005, 16'h0000, 2'h3);
      check(rd, 16'hA5C3);
      xfer(1'h0, 19'h00006, 16'h0000, 2'h3);
      check(rd, 16'h5A3C);
   endtask
   // Every lane pattern on write, then a low-lane read
   task automatic t_lanes();
      for (int le = 0; le < 4; le++) begin
         xfer(1'h1, 19'h00009, 16'h0F0F, 2'h3);
         xfer(1'h1, 19'h00009, 16'hF0F0, le[1:0]);
         xfer(1'h0, 19'h00009, 16'h0000, 2'h3);
         check(rd, {le[1] ? 8'hF0 : 8'h0F, le[0] ? 8'hF0 : 8'h0F});
      end
      xfer(1'h0, 19'h00005, 16'h0000, 2'h1);
      check({8'h00, rd[7:0]}, 16'h00C3);
   endtask
   // Slow memory answering just inside the read window
   task automatic t_slow();
      u_mem.dly = 65;
      xfer(1'h0, 19'h00006, 16'h0000, 2'h3);
      check(rd, 16'h5A3C);
      u_mem.dly = 10;
   endtask
   // Reset in the middle of a write pulse; the request waits for the read turnaround
   task automatic t_reset();
      req_in = '{1'h1, 19'h00011, 16'hFFFF, 2'h3};
      req_valid_in = 1'h1;
      while (req_ready_out !== 1'h1) begin
         tick(1);
      end
      tick(1);
      req_valid_in = 1'h0;
      tick(1);
      check({15'h0, pins_out.sram_write_strobe_n}, 16'h0000);
      tick(1);
      rst_n_in = 1'h0;
      tick(3);
      check(idle_bits(), 16'h00BD);
      rst_n_in = 1'h1;
   endtask
   // Main sequence
   initial begin
      tick(3);
      rst_n_in = 1'h1;
      check(idle_bits(), 16'h00BD);
      t_word();
      t_lanes();
      t_slow();
      t_reset();
      t_word();
      wrap_up();
   end
   // Watchdog
   initial begin
      #30000;
      bad_count++;
      wrap_up();
   end
endmodule // asr_ctrl_test
